// file: shared/adcs_consts.vh
// Constants for the converter sequencer: offsets, fields, resets, timing
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH
// Register offsets (byte index on the plain register port)
`define ADCS_OFF_CTRL      3'h0
`define ADCS_OFF_RES_HI    3'h1
`define ADCS_OFF_RES_LO    3'h2
`define ADCS_OFF_IRQ_STAT  3'h3
`define ADCS_OFF_IRQ_MASK  3'h4
`define ADCS_OFF_PWR       3'h5
// Control register fields
`define ADCS_CTRL_SEL_LSB  4
`define ADCS_CTRL_SEL_MSB  7
`define ADCS_CTRL_MUX      3
`define ADCS_CTRL_DIFF     2
`define ADCS_CTRL_DIV      1
`define ADCS_CTRL_ACTIVE   0
// Reset values
`define ADCS_CTRL_RST      8'h00
`define ADCS_MASK_RST      2'h0
// Interrupt status bits
`define ADCS_IRQ_DONE      0
`define ADCS_IRQ_ABORT     1
// Timing in converter clocks
`define ADCS_SAMPLE_CYC    4'h3
`define ADCS_ZERO_CYC      4'h1
`define ADCS_CONV_CYC      4'hA
`define ADCS_LOAD_CYC      4'h1
`define ADCS_TOTAL_CYC     5'h0F
`define ADCS_DIV_SLOW      5'h10
`endif

// file: rtl/adcs_sequencer.v
// Converter sequencer: control register, prescaler, 15-cycle sequence, results
`timescale 1ns/1ns
`include "adcs_consts.vh"

// Summary of operation
// - Mode bit 0 selects single-ended, 1 selects differential conversion.
// - Prescaler bit 0 divides core clock by 1, bit 1 by 16.
// - Active bit clear keeps prescaler disabled and converter clock stopped.
// - Setting active bit starts clock and conversion with current control values.
// - Normal completion clears active bit and powers converter down.
// - Result registers hold value until next completed conversion or software write; no reset.
// - Software may write and read both result registers.
// - High holds result 9..2; low holds 1..0 in bits 7..6, rest zero.
// - Each conversion completes on the sixteenth converter clock after start.
// - Sample phase starts at first converter edge after start, lasts three clocks.
// - Phases: three sample, one auto-zero, ten convert, one load.
// - Completion loads the 10-bit result into both result registers together.
// - While active, writes to all control bits except active bit are ignored.
// - When idle, one write loads new fields and sets active bit.
// - Halt or idle mode powers converter down; conversion restarts, result invalid.
// - Mux-path bit 1 keeps selected channel routed to mux output always.
module adcs_sequencer #(
  parameter SEL_W = 4,
  parameter RES_W = 10
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // Register port
  input  wire [2:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [7:0]       reg_rdata,
  // Power-save request from the core
  input  wire             power_save,
  // Converter clock and power
  output wire             conv_clk_en,
  output wire             conv_clk_tick,
  output wire             conv_power,
  // Sequence phases
  output wire             sample_on,
  output wire             auto_zero,
  output wire             bit_phase,
  output wire [3:0]       bit_index,
  // Channel selection
  output wire             diff_mode_sel,
  output wire [SEL_W-1:0] input_select,
  output wire             mux_out_en,
  output wire             chan_route_en,
  // Trial word and comparator
  output reg  [RES_W-1:0] sar_trial,
  input  wire             cmp_in,
  // Interrupt
  output wire             irq
);

  localparam ST_IDLE   = 3'h0;
  localparam ST_SAMPLE = 3'h1;
  localparam ST_ZERO   = 3'h2;
  localparam ST_CONV   = 3'h3;
  localparam ST_LOAD   = 3'h4;

  reg  [7:0]       ctrl_r;
  reg  [7:0]       ctrl_nxt;
  reg  [2:0]       state_r;
  reg  [2:0]       state_nxt;
  reg  [3:0]       phase_cnt_r;
  reg  [3:0]       phase_cnt_nxt;
  reg  [4:0]       div_cnt_r;
  reg  [7:0]       res_hi_r;
  reg  [1:0]       res_lo_r;
  reg  [RES_W-1:0] sar_nxt;
  reg  [1:0]       irq_stat_r;
  reg  [1:0]       irq_mask_r;
  reg  [4:0]       div_cnt_nxt;
  reg  [7:0]       res_hi_nxt;
  reg  [1:0]       res_lo_nxt;
  reg  [1:0]       irq_stat_nxt;
  reg  [1:0]       irq_mask_nxt;
  reg  [7:0]       rdata_nxt;
  reg              ph_sample;
  reg              ph_zero;
  reg              ph_conv;
  wire [RES_W-1:0] trial_bit;
  wire [RES_W-1:0] next_bit;
  wire             sel_ctrl;
  wire             sel_res_hi;
  wire             sel_res_lo;
  wire             sel_stat;
  wire             sel_mask;
  wire             sel_state;
  wire             stat_clr;
  wire [1:0]       stat_set;
  reg              ps_s1_r;
  reg              ps_s2_r;
  reg              ps_d_r;
  wire             active;
  wire             tick;
  wire             done;
  wire             ps_exit;
  wire             wr_ctrl;
  wire [4:0]       div_val;

  assign active = ctrl_r[`ADCS_CTRL_ACTIVE];
  assign div_val = ctrl_r[`ADCS_CTRL_DIV] ? `ADCS_DIV_SLOW : 5'h01;
  // Converter clock tick; prescaler held while idle or in power save
  assign tick = active && !ps_s2_r && (div_cnt_r == div_val - 5'h01);
  assign done = tick && (state_r == ST_LOAD);
  assign ps_exit = ps_d_r && !ps_s2_r;
  // Register address decode
  assign sel_ctrl   = reg_addr == `ADCS_OFF_CTRL;
  assign sel_res_hi = reg_addr == `ADCS_OFF_RES_HI;
  assign sel_res_lo = reg_addr == `ADCS_OFF_RES_LO;
  assign sel_stat   = reg_addr == `ADCS_OFF_IRQ_STAT;
  assign sel_mask   = reg_addr == `ADCS_OFF_IRQ_MASK;
  assign sel_state  = reg_addr == `ADCS_OFF_PWR;
  assign wr_ctrl    = reg_wr && sel_ctrl;
  // Read clear and event sets for the status bits
  assign stat_clr   = reg_rd && sel_stat;
  assign stat_set   = {ps_exit && active, done};
  // Trial bit under test and the one tried next
  assign trial_bit  = {{(RES_W-1){1'b0}}, 1'b1} << (phase_cnt_r - 4'h1);
  assign next_bit   = trial_bit >> 1;

  // Two-flop synchroniser for the power-save request
  always @(posedge mclk) begin
    if (!rst_n) begin
      ps_s1_r  <= 1'b0;
      ps_s2_r  <= 1'b0;
      ps_d_r   <= 1'b0;
    end else begin
      ps_s1_r  <= power_save;
      ps_s2_r  <= ps_s1_r;
      ps_d_r   <= ps_s2_r;
    end
  end

  // Prescaler counter next value
  always @* begin
    div_cnt_nxt = div_cnt_r + 5'h01;
    if (!active || ps_s2_r) begin
      div_cnt_nxt = 5'h00;
    end else if (tick) begin
      div_cnt_nxt = 5'h00;
    end
  end

  // Prescaler counter
  always @(posedge mclk) begin
    if (!rst_n) begin
      div_cnt_r <= 5'h00;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // Control register next value
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      if (active) begin
        ctrl_nxt[`ADCS_CTRL_ACTIVE] = reg_wdata[`ADCS_CTRL_ACTIVE];
      end else begin
        ctrl_nxt = reg_wdata;
      end
    end else if (done) begin
      ctrl_nxt[`ADCS_CTRL_ACTIVE] = 1'b0;
    end
  end

  // Sequencer
  always @* begin
    state_nxt = state_r;
    phase_cnt_nxt = phase_cnt_r;
    sar_nxt = sar_trial;
    if (!active || ps_s2_r) begin
      // Power down restarts from sample phase if active, else returns to idle
      state_nxt = active ? ST_SAMPLE : ST_IDLE;
      phase_cnt_nxt = `ADCS_SAMPLE_CYC;
      sar_nxt = {1'b1, {(RES_W-1){1'b0}}};
    end else if (tick) begin
      phase_cnt_nxt = phase_cnt_r - 4'h1;
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_SAMPLE;
          phase_cnt_nxt = `ADCS_SAMPLE_CYC;
        end
        ST_SAMPLE: begin
          if (phase_cnt_r == 4'h1) begin
            state_nxt = ST_ZERO;
            phase_cnt_nxt = `ADCS_ZERO_CYC;
          end
        end
        ST_ZERO: begin
          state_nxt = ST_CONV;
          phase_cnt_nxt = `ADCS_CONV_CYC;
        end
        ST_CONV: begin
          // Comparator sits in the converter macro on mclk; no synchroniser
          if (!cmp_in) begin
            sar_nxt = sar_trial & ~trial_bit;
          end
          if (phase_cnt_r != 4'h1) begin
            sar_nxt = sar_nxt | next_bit;
          end else begin
            state_nxt = ST_LOAD;
            phase_cnt_nxt = `ADCS_LOAD_CYC;
          end
        end
        ST_LOAD: begin
          state_nxt = ST_IDLE;
          phase_cnt_nxt = `ADCS_SAMPLE_CYC;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Control register
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= `ADCS_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Sequencer state
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Phase down-counter
  always @(posedge mclk) begin
    if (!rst_n) begin
      phase_cnt_r <= `ADCS_SAMPLE_CYC;
    end else begin
      phase_cnt_r <= phase_cnt_nxt;
    end
  end

  // Trial word
  always @(posedge mclk) begin
    if (!rst_n) begin
      sar_trial <= {RES_W{1'b0}};
    end else begin
      sar_trial <= sar_nxt;
    end
  end

  // Result next values; hardware load beats a software write
  always @* begin
    res_hi_nxt = res_hi_r;
    res_lo_nxt = res_lo_r;
    if (done) begin
      res_hi_nxt = sar_trial[RES_W-1:RES_W-8];
      res_lo_nxt = sar_trial[1:0];
    end else if (reg_wr) begin
      if (sel_res_hi) begin
        res_hi_nxt = reg_wdata;
      end
      if (sel_res_lo) begin
        res_lo_nxt = reg_wdata[7:6];
      end
    end
  end

  // Result registers, not reset
  always @(posedge mclk) begin
    res_hi_r <= res_hi_nxt;
    res_lo_r <= res_lo_nxt;
  end

  // Interrupt status and mask next values; set wins over read clear
  always @* begin
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    if (stat_clr) begin
      irq_stat_nxt = 2'h0;
    end
    irq_stat_nxt = irq_stat_nxt | stat_set;
    if (reg_wr && sel_mask) begin
      irq_mask_nxt = reg_wdata[1:0];
    end
  end

  // Interrupt status and mask
  always @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= `ADCS_MASK_RST;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Read data select
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (sel_ctrl) begin
        rdata_nxt = ctrl_r;
      end
      if (sel_res_hi) begin
        rdata_nxt = res_hi_r;
      end
      if (sel_res_lo) begin
        rdata_nxt = {res_lo_r, 6'h00};
      end
      if (sel_stat) begin
        rdata_nxt = {6'h00, irq_stat_r};
      end
      if (sel_mask) begin
        rdata_nxt = {6'h00, irq_mask_r};
      end
      if (sel_state) begin
        rdata_nxt = {5'h00, state_r};
      end
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Phase decode
  always @* begin
    ph_sample = 1'b0;
    ph_zero = 1'b0;
    ph_conv = 1'b0;
    case (state_r)
      ST_SAMPLE: begin
        ph_sample = 1'b1;
      end
      ST_ZERO: begin
        ph_zero = 1'b1;
      end
      ST_CONV: begin
        ph_conv = 1'b1;
      end
      default: begin
      end
    endcase
  end

  assign irq = |(irq_stat_r & irq_mask_r);
  assign conv_clk_en = active && !ps_s2_r;
  assign conv_clk_tick = tick;
  assign conv_power = active && !ps_s2_r;
  assign sample_on = ph_sample && conv_power;
  assign auto_zero = ph_zero;
  assign bit_phase = ph_conv;
  assign bit_index = phase_cnt_r;
  assign diff_mode_sel = ctrl_r[`ADCS_CTRL_DIFF];
  assign input_select = ctrl_r[`ADCS_CTRL_SEL_MSB:`ADCS_CTRL_SEL_LSB];
  assign mux_out_en = ctrl_r[`ADCS_CTRL_MUX];
  assign chan_route_en = mux_out_en || conv_power;

endmodule // adcs_sequencer

// file: tb/adcs_cmp_model.sv
// Comparator model for the analog side
`timescale 1ns/1ns
module adcs_cmp_model (
  input  wire logic       mclk,
  input  wire logic       conv_power,
  input  wire logic [9:0] sar_trial,
  input  wire logic [9:0] vin,
  output logic            cmp_in
);
  logic tog = 1'b0;
  always @(posedge mclk) tog <= ~tog;
  // Unpowered comparator output wanders
  assign cmp_in = conv_power ? (vin >= sar_trial) : tog;
endmodule // adcs_cmp_model

// file: tb/adcs_monitor.sv
// Assertion checker for the converter sequencer ports
`timescale 1ns/1ns
module adcs_monitor #(parameter SEL_W = 4) (
  input wire logic             mclk, rst_n, reg_rd, conv_clk_en, conv_clk_tick, conv_power,
  input wire logic             sample_on, auto_zero, bit_phase, diff_mode_sel, mux_out_en, chan_route_en,
  input wire logic [7:0]       reg_rdata,
  input wire logic [3:0]       bit_index,
  input wire logic [SEL_W-1:0] input_select
);
  logic [3:0] sc, zc, bc;
  // Ticks seen in each phase
  always @(posedge mclk) begin
    sc <= sample_on ? sc + {3'h0, conv_clk_tick} : 4'h0;
    zc <= auto_zero ? zc + {3'h0, conv_clk_tick} : 4'h0;
    bc <= bit_phase ? bc + {3'h0, conv_clk_tick} : 4'h0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  tick_gate_a: assert property (!conv_clk_en |-> !conv_clk_tick) else $error("tick while off");
  sample_len_a: assert property ($fell(sample_on) && conv_clk_en |-> sc == 4'h3) else $error("sample len");
  zero_len_a: assert property ($fell(auto_zero) && conv_clk_en |-> zc == 4'h1) else $error("zero len");
  conv_len_a: assert property ($fell(bit_phase) && conv_clk_en |-> bc == 4'hA) else $error("bit len");
  load_end_a: assert property ($fell(bit_phase) && conv_clk_en |-> ##[1:17] !conv_power)
    else $error("no stop");
  first_samp_a: assert property ($rose(conv_power) |-> ##[1:20] sample_on) else $error("no sample");
  phase_one_a: assert property ($onehot0({sample_on, auto_zero, bit_phase})) else $error("phases");
  mux_route_a: assert property (mux_out_en |-> chan_route_en) else $error("route off");
  field_hold_a: assert property (conv_power && $past(conv_power) |-> $stable(input_select)
    && $stable(diff_mode_sel)) else $error("fields moved");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray rdata");
  bit_index_a: assert property (bit_phase |-> bit_index >= 4'h1 && bit_index <= 4'hA)
    else $error("bit index");
endmodule // adcs_monitor

bind adcs_sequencer adcs_monitor #(.SEL_W(SEL_W)) u_mon (.*);

// file: tb/adc_conversion_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`include "adcs_consts.vh"
module adc_conversion_sequencer_tb;
  logic       mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, power_save = 1'b0, rd_q = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rv;
  logic [9:0] vin = 10'h000, sar_trial;
  logic [3:0] input_select, bit_index;
  logic       conv_clk_en, conv_clk_tick, conv_power, sample_on, auto_zero, bit_phase;
  logic       diff_mode_sel, mux_out_en, chan_route_en, cmp_in, irq;
  logic [8:0] expq[$];
  logic [8:0] e;
  int         failures = 0, tests_run = 0;
  initial forever #20 mclk = ~mclk;
  adcs_sequencer uut (.*);
  adcs_cmp_model u_cmp (.*);
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic c, input logic [7:0] x);
    @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1; expq.push_back({c, x});
    @(posedge mclk); reg_rd <= 1'b0;
    @(posedge mclk); rv = reg_rdata;
  endtask
  // Read data checked in the cycle after the strobe
  always @(posedge mclk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      e = expq.pop_front();
      if (e[8]) chk("rdata", e[7:0], reg_rdata);
    end
  end
  task automatic results();
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 200; i++) begin
      rd(`ADCS_OFF_CTRL, 1'b0, 8'h00);
      if (rv[0] === 1'b0) break;
    end
    if (i == 200) begin failures++; results(); end
  endtask
  task automatic conv(input logic [7:0] c, input logic ie);
    int n;
    vin <= 10'($urandom);
    wr(`ADCS_OFF_CTRL, c);
    @(negedge mclk);
    chk("fields", {2'h0, c[7:2]}, {2'h0, input_select, mux_out_en, diff_mode_sel});
    wr(`ADCS_OFF_CTRL, {~c[7:1], 1'b1});
    @(negedge mclk);
    chk("held", {2'h0, c[7:2]}, {2'h0, input_select, mux_out_en, diff_mode_sel});
    n = 0;
    while (conv_clk_tick !== 1'b1 && n < 40) begin @(negedge mclk); n++; end
    @(negedge mclk); n = 1;
    while (conv_clk_tick !== 1'b1 && n < 40) begin @(negedge mclk); n++; end
    chk("div", c[1] ? 8'h10 : 8'h01, 8'(n));
    wait_idle();
    chk("irq", {7'h00, ie}, {7'h00, irq});
    rd(`ADCS_OFF_RES_HI, 1'b1, vin[9:2]);
    rd(`ADCS_OFF_RES_LO, 1'b1, {vin[1:0], 6'h00});
    rd(`ADCS_OFF_IRQ_STAT, 1'b1, 8'h01);
    @(negedge mclk);
    chk("irq clr", 8'h00, {7'h00, irq});
  endtask
  initial begin
    void'($urandom(73));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`ADCS_OFF_CTRL, 1'b1, 8'h00);
    rd(3'h6, 1'b1, 8'h00);
    wr(`ADCS_OFF_RES_HI, 8'hA5);
    wr(`ADCS_OFF_RES_LO, 8'hFF);
    rd(`ADCS_OFF_RES_HI, 1'b1, 8'hA5);
    rd(`ADCS_OFF_RES_LO, 1'b1, 8'hC0);
    wr(`ADCS_OFF_IRQ_MASK, 8'h01);
    for (int m = 0; m < 4; m++) conv({4'($urandom), 1'b0, 2'(m), 1'b1}, 1'b1);
    wr(`ADCS_OFF_CTRL, 8'h35);
    wr(`ADCS_OFF_CTRL, 8'h34);
    conv(8'hC7, 1'b1);
    wr(`ADCS_OFF_IRQ_MASK, 8'h00);
    conv(8'h91, 1'b0);
    wr(`ADCS_OFF_CTRL, 8'hE8);
    @(negedge mclk);
    chk("mux", 8'h06, {5'h00, mux_out_en, chan_route_en, conv_power});
    wr(`ADCS_OFF_CTRL, 8'h01);
    repeat (6) @(posedge mclk);
    power_save <= 1'b1;
    repeat (8) @(negedge mclk);
    chk("halt", 8'h00, {7'h00, conv_clk_en});
    @(posedge mclk);
    power_save <= 1'b0;
    wait_idle();
    rd(`ADCS_OFF_IRQ_STAT, 1'b1, 8'h03);
    results();
  end
endmodule // adc_conversion_sequencer_tb
